/* common/slwt_pkg.sv */
// sleep wakeup timer package: offsets, reset values, carriers
`default_nettype none
package slwt_pkg;
  localparam logic [7:0] SLWT_ADDR_LOW = 8'h95;
  localparam logic [7:0] SLWT_ADDR_MID = 8'h96;
  localparam logic [7:0] SLWT_ADDR_HIGH = 8'h97;
  localparam logic [7:0] SLWT_BYTE_RST = 8'h00;
  localparam logic [23:0] SLWT_CMP_RST = 24'hFFFFFF;
  localparam logic [23:0] SLWT_CNT_RST = 24'h000000;
  localparam int SLWT_DMA_TRIG_NUM = 11;

  typedef enum logic [1:0] {
    SLWT_PM_ACTIVE = 2'h0,
    SLWT_PM_LIGHT = 2'h1,
    SLWT_PM_DEEP = 2'h3,
    SLWT_PM_OFF = 2'h2
  } slwt_pmode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } slwt_sfr_req_t;
endpackage
`default_nettype wire

/* design/slwt_top.sv */
// sleep wakeup timer: 24-bit counter on the low-speed tick with compare
`timescale 1ns/1ps
`default_nettype none
// Operation
// - the counter is 24 bits and advances once per low-speed clock period.
// - counting starts at reset release, stops only in full off and never reloads.
// - count equal to compare value sets the sleep match flag.
// - the three byte registers read count bytes and write compare bytes.
// - reading the low byte captures the whole count for later byte reads.
// - mid and high writes are held until the low byte write commits all.
// - compare resets to all ones, byte registers show zero after reset.
// - the counter runs in every power mode except full off.
// - in light or deep sleep a compare event requests wake to active.
// - a separate interrupt enable bit gates the sleep interrupt.
// - each compare event pulses the sleep DMA trigger, number 11.
module slwt_top (
  input wire logic clk, // 10 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic lowspd_tick, // one pulse per 32 kHz period
  input wire slwt_pkg::slwt_pmode_t pmode, // current power mode
  input wire slwt_pkg::slwt_sfr_req_t sfr_req, // sfr bus request
  output logic [7:0] sfr_rdata, // sfr read data
  input wire logic irq_enable_wr, // write strobe for the enable bit
  input wire logic irq_enable_wdata, // new enable bit value
  input wire logic flag_wr, // write strobe for the flag bit
  input wire logic flag_wdata, // new flag bit value
  output logic sleep_match_irq_enable, // interrupt enable bit
  output logic sleep_match_flag, // sticky match flag
  output logic sleep_irq, // interrupt request
  output logic dma_trig, // one-cycle dma trigger
  output logic wake_req // one-cycle wake to active request
);
  logic [23:0] count_r;
  logic [23:0] count_nxt;
  logic [23:0] cmp_r;
  logic [23:0] cmp_nxt;
  logic [23:0] snap_r;
  logic [23:0] snap_nxt;
  logic [7:0] hold_mid_r;
  logic [7:0] hold_mid_nxt;
  logic [7:0] hold_high_r;
  logic [7:0] hold_high_nxt;
  logic tick_d_r;
  logic tick_d_nxt;
  logic enable_nxt;
  logic flag_nxt;
  logic irq_nxt;
  logic dma_nxt;
  logic wake_nxt;
  logic running;
  logic sleeping;
  logic advance;
  logic match_evt;
  logic enable_eff;
  logic rd_low;
  logic rd_mid;
  logic rd_high;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic [7:0] rdata_nxt;

  // power mode qualifiers
  assign running = (pmode != slwt_pkg::SLWT_PM_OFF);
  assign sleeping = (pmode == slwt_pkg::SLWT_PM_LIGHT) ||
    (pmode == slwt_pkg::SLWT_PM_DEEP);
  assign advance = lowspd_tick && running;

  // address decode, one strobe per mapped byte
  always_comb begin
    rd_low = 1'b0;
    rd_mid = 1'b0;
    rd_high = 1'b0;
    wr_low = 1'b0;
    wr_mid = 1'b0;
    wr_high = 1'b0;
    case (sfr_req.addr)
      slwt_pkg::SLWT_ADDR_LOW: begin
        rd_low = sfr_req.rd;
        wr_low = sfr_req.wr;
      end
      slwt_pkg::SLWT_ADDR_MID: begin
        rd_mid = sfr_req.rd;
        wr_mid = sfr_req.wr;
      end
      slwt_pkg::SLWT_ADDR_HIGH: begin
        rd_high = sfr_req.rd;
        wr_high = sfr_req.wr;
      end
      default: begin
        rd_low = 1'b0;
        wr_low = 1'b0;
      end
    endcase
  end

  // free-running count, wraps from all ones to zero
  always_comb begin
    if (advance) begin
      count_nxt = count_r + 24'h000001;
    end else begin
      count_nxt = count_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= slwt_pkg::SLWT_CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // tick delayed so the compare sees the count just reached
  always_comb begin
    tick_d_nxt = advance;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick_d_nxt;
    end
  end

  // one compare event per tick, not while the count stays equal
  assign match_evt = tick_d_r && (count_r == cmp_r);

  // whole count captured on a low byte read
  always_comb begin
    if (rd_low) begin
      snap_nxt = count_r;
    end else begin
      snap_nxt = snap_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= {3{slwt_pkg::SLWT_BYTE_RST}};
    end else begin
      snap_r <= snap_nxt;
    end
  end

  // middle compare byte held until the low byte commits
  always_comb begin
    if (wr_mid) begin
      hold_mid_nxt = sfr_req.wdata;
    end else begin
      hold_mid_nxt = hold_mid_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_mid_r <= slwt_pkg::SLWT_BYTE_RST;
    end else begin
      hold_mid_r <= hold_mid_nxt;
    end
  end

  // high compare byte held until the low byte commits
  always_comb begin
    if (wr_high) begin
      hold_high_nxt = sfr_req.wdata;
    end else begin
      hold_high_nxt = hold_high_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_high_r <= slwt_pkg::SLWT_BYTE_RST;
    end else begin
      hold_high_r <= hold_high_nxt;
    end
  end

  // low byte write commits all three bytes at once
  always_comb begin
    if (wr_low) begin
      cmp_nxt = {hold_high_r, hold_mid_r, sfr_req.wdata};
    end else begin
      cmp_nxt = cmp_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_r <= slwt_pkg::SLWT_CMP_RST;
    end else begin
      cmp_r <= cmp_nxt;
    end
  end

  // low byte live, middle and high from the capture
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_low) begin
      rdata_nxt = count_r[7:0];
    end else if (rd_mid) begin
      rdata_nxt = snap_r[15:8];
    end else if (rd_high) begin
      rdata_nxt = snap_r[23:16];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= slwt_pkg::SLWT_BYTE_RST;
    end else begin
      sfr_rdata <= rdata_nxt;
    end
  end

  // interrupt enable, kept apart from the flag
  always_comb begin
    if (irq_enable_wr) begin
      enable_nxt = irq_enable_wdata;
    end else begin
      enable_nxt = sleep_match_irq_enable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_match_irq_enable <= 1'b0;
    end else begin
      sleep_match_irq_enable <= enable_nxt;
    end
  end

  // a same-cycle enable write already gates the request
  assign enable_eff = irq_enable_wr ? irq_enable_wdata :
    sleep_match_irq_enable;

  // set wins over a clear in the same cycle
  always_comb begin
    flag_nxt = sleep_match_flag;
    if (match_evt) begin
      flag_nxt = 1'b1;
    end else if (flag_wr) begin
      flag_nxt = flag_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_match_flag <= 1'b0;
    end else begin
      sleep_match_flag <= flag_nxt;
    end
  end

  // request follows flag and enable together
  always_comb begin
    irq_nxt = (sleep_match_flag || match_evt) && enable_eff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_irq <= 1'b0;
    end else begin
      sleep_irq <= irq_nxt;
    end
  end

  // one-cycle dma trigger per compare event
  always_comb begin
    dma_nxt = match_evt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_trig <= 1'b0;
    end else begin
      dma_trig <= dma_nxt;
    end
  end

  // wake only out of light or deep sleep
  always_comb begin
    wake_nxt = match_evt && sleeping;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= wake_nxt;
    end
  end
endmodule // slwt_top
`default_nettype wire

/* sim/sleep_wakeup_timer_tb.sv */
// sleep wakeup timer testbench
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module sleep_wakeup_timer_tb;
  logic clk = 0, rst_n = 0, tk = 0, ew = 0, ed = 0, fw = 0, fd = 0;
  slwt_pkg::slwt_pmode_t pm = slwt_pkg::SLWT_PM_ACTIVE;
  slwt_pkg::slwt_sfr_req_t rq = '0;
  logic [7:0] rdat, v;
  logic en, fl, irq, dt, wk, d, w;
  logic [23:0] cnt = 0;
  logic [1:0] md [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0] ex [4] = '{2'h2, 2'h3, 2'h3, 2'h0};
  int fails = 0, n_compared = 0;
  slwt_top dut (.clk(clk), .rst_n(rst_n), .lowspd_tick(tk), .pmode(pm),
    .sfr_req(rq), .sfr_rdata(rdat), .irq_enable_wr(ew),
    .irq_enable_wdata(ed), .flag_wr(fw), .flag_wdata(fd),
    .sleep_match_irq_enable(en), .sleep_match_flag(fl), .sleep_irq(irq),
    .dma_trig(dt), .wake_req(wk));
  initial forever #50 clk = ~clk;
  task complete_run;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task bus(input logic r, input logic [7:0] a, dv);
    @(negedge clk) rq = {r, ~r, a, dv};
    @(negedge clk) rq = '0;
    v = rdat;
  endtask
  task tick;
    @(negedge clk) tk = 1;
    @(negedge clk) tk = 0;
    if (pm != slwt_pkg::SLWT_PM_OFF) cnt++;
    @(negedge clk) {d, w} = {dt, wk};
    @(negedge clk);
  endtask
  task setc(input logic [23:0] c);
    bus(0, 8'h97, c[23:16]);
    bus(0, 8'h96, c[15:8]);
    bus(0, 8'h95, c[7:0]);
  endtask
  task sb(input logic a, b, c, e);
    @(negedge clk) {ew, ed, fw, fd} = {a, b, c, e};
    @(negedge clk) {ew, ed, fw, fd} = 4'h0;
    @(negedge clk);
  endtask
  initial begin
    #500000 fails++;
    complete_run;
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    bus(1, 8'h97, 8'h00); `CK("high", 8'h00, v)
    bus(1, 8'h94, 8'h00); `CK("unmapped", 8'h00, v)
    for (int i = 0; i < 4; i++) begin
      setc(cnt + 24'h000001);
      pm = slwt_pkg::slwt_pmode_t'(md[i]);
      tick;
      `CK("dma", ex[i][1], d)
      `CK("wake", ex[i][0], w)
      `CK("flag", ex[i][1], fl)
      sb(0, 0, 1, 0);
    end
    pm = slwt_pkg::SLWT_PM_ACTIVE;
    bus(1, 8'h95, 8'h00); `CK("frozen", cnt[7:0], v)
    setc(24'h000000);
    bus(0, 8'h96, 8'h01);
    while (cnt < 24'h0000FF) tick;
    bus(1, 8'h95, 8'h00); `CK("low", 8'hFF, v)
    tick; `CK("held", 1'b0, d)
    bus(1, 8'h96, 8'h00); `CK("snap", 8'h00, v)
    bus(1, 8'h95, 8'h00);
    bus(1, 8'h96, 8'h00); `CK("mid", 8'h01, v)
    bus(0, 8'h95, 8'h02);
    tick;
    tick; `CK("commit", 1'b1, d)
    `CK("gated", 1'b0, irq)
    sb(1, 1, 0, 0); `CK("irq", 1'b1, irq)
    sb(0, 0, 1, 0); `CK("clear", 2'h0, {fl, irq})
    complete_run;
  end
endmodule // sleep_wakeup_timer_tb
`default_nettype wire

/* sim/slwt_asserts.sv */
// sleep wakeup timer checker
`timescale 1ns/1ps
`default_nettype none
module slwt_asserts (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic lowspd_tick, // tick
  input wire slwt_pkg::slwt_pmode_t pmode, // mode
  input wire slwt_pkg::slwt_sfr_req_t sfr_req, // bus
  input wire logic [7:0] sfr_rdata, // data
  input wire logic flag_wr, // strobe
  input wire logic flag_wdata, // data
  input wire logic sleep_match_irq_enable, // enable
  input wire logic sleep_match_flag, // flag
  input wire logic sleep_irq, // irq
  input wire logic dma_trig, // dma
  input wire logic wake_req // wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence tick_ago; $past(lowspd_tick, 2); endsequence
  sequence slept;
    $past(pmode) == slwt_pkg::SLWT_PM_LIGHT ||
      $past(pmode) == slwt_pkg::SLWT_PM_DEEP;
  endsequence
  sequence evt_slept; dma_trig ##0 slept; endsequence
  trig_cause_a: assert property (dma_trig |-> tick_ago)
    else $error("trigger without tick");
  dma_pulse_a: assert property (dma_trig |=> !dma_trig)
    else $error("trigger too long");
  flag_set_a: assert property (dma_trig |-> sleep_match_flag)
    else $error("flag missing");
  wake_cause_a: assert property (wake_req |-> evt_slept)
    else $error("stray wake");
  wake_due_a: assert property (evt_slept |-> wake_req)
    else $error("wake missing");
  irq_gate_a: assert property (sleep_irq |-> sleep_match_irq_enable)
    else $error("irq not enabled");
  irq_due_a: assert property (sleep_match_flag && sleep_match_irq_enable
    |=> sleep_irq) else $error("irq missing");
  flag_hold_a: assert property ($fell(sleep_match_flag) |->
    $past(flag_wr && !flag_wdata)) else $error("flag lost");
  idle_read_a: assert property (!$past(sfr_req.rd) |-> sfr_rdata == 8'h00)
    else $error("stray data");
endmodule // slwt_asserts
bind slwt_top slwt_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .lowspd_tick(lowspd_tick), .pmode(pmode), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
  .sleep_match_irq_enable(sleep_match_irq_enable), .sleep_irq(sleep_irq),
  .sleep_match_flag(sleep_match_flag), .dma_trig(dma_trig),
  .wake_req(wake_req));
`default_nettype wire
